// >>> ubr_defines.svh
/*
  Timing and sizing constants for the uplink bi-phase link, both ends.
  Assumes a 100 MHz system clock at each end and the nominal line rate.
*/
`ifndef UBR_DEFINES_SVH
`define UBR_DEFINES_SVH

// Clock and line rate in Hz
`define UBR_CLK_HZ 32'h05F5E100
`define UBR_BIT_RATE_HZ 32'h00089D00

// Rate generators: modulus and increments per clock
`define UBR_NCO_W 28
`define UBR_NCO_MOD 28'(`UBR_CLK_HZ)
`define UBR_BIT_INC 28'(`UBR_BIT_RATE_HZ)
`define UBR_HALF_INC 28'(32'h2 * `UBR_BIT_RATE_HZ)

// One bit cell in clock cycles, rounded down
`define UBR_CELL_CYC (`UBR_CLK_HZ / `UBR_BIT_RATE_HZ)
`define UBR_CNT_W 9
`define UBR_QTR_CYC 9'(`UBR_CELL_CYC / 32'h4)
`define UBR_3QTR_CYC 9'((32'h3 * `UBR_CELL_CYC) / 32'h4)
`define UBR_LOST_CYC 9'((32'h3 * `UBR_CELL_CYC) / 32'h2)

// Loss deadline and acquisition budget, in bit periods
`define UBR_LOSS_BITS 32'h155
`define UBR_ACQ_BITS 32'h12C
`define UBR_ACQ_W 16

// Separator run inserted between telegrams
`define UBR_GAP_W 7
`define UBR_GAP_BITS 7'h64

// Stored fallback telegram
`define UBR_TGM_LEN 1023
`define UBR_IDX_W 10
`define UBR_TGM_LAST 10'h3FE

`endif

// >>> ubr_pkg.sv
/*
  Types shared by both ends of the uplink bi-phase link.
  Assumes ubr_defines.svh is on the include path.
*/
`include "ubr_defines.svh"

package ubr_pkg;

  typedef enum logic [2:0] {
    UBR_RX_ACQ = 3'h1,
    UBR_RX_TRACK = 3'h2,
    UBR_RX_FALLBACK = 3'h4
  } ubr_rx_state_e;

  typedef struct packed {
    ubr_rx_state_e state;
    logic prev_lvl;
    logic [`UBR_CNT_W-1:0] cnt;
    logic bnd_seen;
    logic [`UBR_ACQ_W-1:0] acq_cnt;
    logic [`UBR_GAP_W-1:0] gap_cnt;
    logic [`UBR_IDX_W-1:0] idx;
    logic [`UBR_NCO_W-1:0] nco;
    logic air_bit;
    logic air_stb;
    logic fallback;
    logic locked;
  } ubr_rx_s;

  typedef struct packed {
    logic [`UBR_NCO_W-1:0] nco;
    logic second_half;
    logic lvl;
    logic [`UBR_GAP_W-1:0] gap_cnt;
    logic gap_pend;
    logic take;
  } ubr_tx_s;

endpackage : ubr_pkg

// >>> ubr_link_if.sv
/*
  Telegram input link: one differential line level from encoder to beacon.
  Assumes the testbench may swap the wire pair, i.e. invert line_lvl.
*/
`timescale 1ns/100ps

interface ubr_link_if;
  logic line_lvl;

  modport enc (output line_lvl);
  modport bcn (input line_lvl);
endinterface : ubr_link_if

// >>> ubr_encoder_end.sv
/*
  Wayside encoder end: streams user bits in differential bi-phase-level code.
  Assumes the user always offers the next bit on tx_bit; it is taken on tx_take.
*/
`timescale 1ns/100ps

module ubr_encoder_end
  import ubr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  ubr_link_if.enc link,
  input wire logic tx_bit,
  input wire logic tx_gap_req,
  output logic tx_take,
  output logic tx_gap_busy
);

  ubr_tx_s st_reg;
  ubr_tx_s st_next;
  logic [`UBR_NCO_W:0] acc_sum;
  logic half_tick;
  logic cell_bit;

  always_comb begin
    st_next = st_reg;
    st_next.take = 1'b0;
    cell_bit = 1'b0;
    // Free-running half-cell rate, no pause and nothing from the far end
    acc_sum = {1'b0, st_reg.nco} + {1'b0, `UBR_HALF_INC};
    half_tick = (acc_sum >= {1'b0, `UBR_NCO_MOD});
    if (half_tick) begin
      st_next.nco = `UBR_NCO_W'(acc_sum - {1'b0, `UBR_NCO_MOD});
    end else begin
      st_next.nco = acc_sum[`UBR_NCO_W-1:0];
    end
    if (tx_gap_req) begin
      st_next.gap_pend = 1'b1;
    end
    if (half_tick) begin
      if (!st_reg.second_half) begin
        // Separator run of ones between telegrams
        if (st_reg.gap_cnt != '0) begin
          cell_bit = 1'b1;
          st_next.gap_cnt = st_reg.gap_cnt - 1'b1;
        end else if (st_reg.gap_pend) begin
          cell_bit = 1'b1;
          st_next.gap_cnt = `UBR_GAP_BITS - 1'b1;
          st_next.gap_pend = tx_gap_req;
        end else begin
          cell_bit = tx_bit;
          st_next.take = 1'b1;
        end
        // A one repeats the last letter, so the level must flip at the cell edge
        if (cell_bit) begin
          st_next.lvl = ~st_reg.lvl;
        end
        st_next.second_half = 1'b1;
      end else begin
        // Mid-cell transition in every cell
        st_next.lvl = ~st_reg.lvl;
        st_next.second_half = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.line_lvl = st_reg.lvl;
  assign tx_take = st_reg.take;
  assign tx_gap_busy = st_reg.gap_pend;

endmodule : ubr_encoder_end

// >>> ubr_beacon_end.sv
/*
  Beacon end: recovers bit timing from the line, decodes the differential
  bi-phase-level stream and forwards bits to the air-gap side, or falls back
  to the stored telegram when input quality is lost.
  Assumes line_lvl is synchronous to clock and srst is asserted at each
  new energisation by a train.
  Outputs are registered; air_bit means something only with air_stb.
  Limitation: bursts are not tolerated, one bad edge after lock decides fallback.
*/
// Notes on behaviour
// - Decode only relative transitions, never absolute polarity
// - Mid-cell falling edge is A, rising is B
// - Same letter gives one, different gives zero
// - Nominal line rate 564.48 kbit/s both ends
// - Sender holds rate within 200 ppm per 1500 bits
// - One-way link, no handshake or retransmission
// - Follow sender timing exactly, no flow control
// - Fallback starts within 341 bit periods of loss
// - Constant ones or zeros: forward or fall back
// - Loss detected at activation and mid-passage
// - Fallback holds until de-energised, ignore recovery
// - Each energisation clears the earlier decision
// - Bits pass through without content interpretation
// - Forward all received bits in FIFO order (code drops bits decoded before lock)
// - Separator run of 75 to 128 equal bits
// - Telegram boundaries found from coding, no start bit
`timescale 1ns/100ps

module ubr_beacon_end
  import ubr_pkg::*;
#(
  parameter int ACQ_CYC = `UBR_ACQ_BITS * `UBR_CELL_CYC
) (
  input wire logic clock,
  input wire logic srst,
  ubr_link_if.bcn link,
  input wire logic [`UBR_TGM_LEN-1:0] stored_tgm,
  output logic air_bit,
  output logic air_stb,
  output logic fallback,
  output logic locked
);

  // Every field named, so a new field cannot slip in with an unplanned reset
  localparam ubr_rx_s RX_RESET = '{
    state: UBR_RX_ACQ,
    prev_lvl: 1'b0,
    cnt: '0,
    bnd_seen: 1'b0,
    acq_cnt: '0,
    gap_cnt: '0,
    idx: '0,
    nco: '0,
    air_bit: 1'b0,
    air_stb: 1'b0,
    fallback: 1'b0,
    locked: 1'b0
  };

  ubr_rx_s st_reg;
  ubr_rx_s st_next;
  logic edge_seen;
  logic fault;
  logic [`UBR_NCO_W:0] acc_sum;
  logic bit_tick;

  // Edge classification against the phase counter, plus budget, separator and index flags
  logic edge_early;
  logic edge_bnd_win;
  logic lock_gap;
  logic cnt_lost;
  logic acq_spent;
  logic gap_left;
  logic idx_wrap;

  always_comb begin
    st_next = st_reg;
    st_next.air_stb = 1'b0;
    st_next.prev_lvl = link.line_lvl;
    fault = 1'b0;
    // Only the change of level is used, so swapped wires decode the same
    edge_seen = link.line_lvl ^ st_reg.prev_lvl;
    acc_sum = {1'b0, st_reg.nco} + {1'b0, `UBR_BIT_INC};
    bit_tick = (acc_sum >= {1'b0, `UBR_NCO_MOD});
    // Windows sit at a quarter and three quarters of a nominal cell, so
    // edge jitter of up to a quarter cell passes without a fault
    edge_early = st_reg.cnt < `UBR_QTR_CYC;
    edge_bnd_win = st_reg.cnt < `UBR_3QTR_CYC;
    lock_gap = (st_reg.cnt >= `UBR_3QTR_CYC) && (st_reg.cnt < `UBR_LOST_CYC);
    cnt_lost = st_reg.cnt == `UBR_LOST_CYC - 1'b1;
    acq_spent = st_reg.acq_cnt == `UBR_ACQ_W'(ACQ_CYC);
    gap_left = st_reg.gap_cnt != '0;
    idx_wrap = st_reg.idx == `UBR_TGM_LAST;

    case (st_reg.state)
      UBR_RX_ACQ: begin
        // Budget since energisation, well inside the loss deadline
        st_next.acq_cnt = st_reg.acq_cnt + 1'b1;
        if (st_reg.cnt != `UBR_LOST_CYC) begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
        if (edge_seen) begin
          st_next.cnt = '0;
          // A full-cell gap can only end on a mid-cell edge; a pure run of
          // ones never shows one, so it ends in fallback
          // One clean full-cell gap is enough to lock
          if (lock_gap) begin
            st_next.state = UBR_RX_TRACK;
            st_next.bnd_seen = 1'b0;
            st_next.locked = 1'b1;
          end
        end
        // Budget spent with no lock: nothing valid since energisation
        if (acq_spent) begin
          fault = 1'b1;
        end
      end

      UBR_RX_TRACK: begin
        if (edge_seen) begin
          // Too early for any legal edge: noise or a burst on the line
          if (edge_early) begin
            fault = 1'b1;
          end else if (edge_bnd_win) begin
            // Cell-boundary edge: at most one per cell
            if (st_reg.bnd_seen) begin
              fault = 1'b1;
            end
            // Boundary only marks the cell; the bit leaves on the mid edge
            st_next.bnd_seen = 1'b1;
            st_next.cnt = st_reg.cnt + 1'b1;
          end else begin
            // Mid-cell edge: a boundary flip means the letter repeated
            // Phase is re-anchored here, so the sender's actual rate is
            // followed cell by cell
            st_next.air_bit = st_reg.bnd_seen;
            st_next.air_stb = 1'b1;
            st_next.bnd_seen = 1'b0;
            st_next.cnt = '0;
          end
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
          // No mid-cell edge for one and a half cells: input lost
          if (cnt_lost) begin
            fault = 1'b1;
          end
        end
      end

      UBR_RX_FALLBACK: begin
        // Line is ignored from here on until srst
        // Pace is the nominal rate, as the lost sender's pace is unknown
        if (bit_tick) begin
          st_next.nco = `UBR_NCO_W'(acc_sum - {1'b0, `UBR_NCO_MOD});
          st_next.air_stb = 1'b1;
          if (gap_left) begin
            // Separator of zeros ahead of the stored telegram
            st_next.air_bit = 1'b0;
            st_next.gap_cnt = st_reg.gap_cnt - 1'b1;
          end else begin
            st_next.air_bit = stored_tgm[st_reg.idx];
            if (idx_wrap) begin
              st_next.idx = '0;
            end else begin
              st_next.idx = st_reg.idx + 1'b1;
            end
          end
        end else begin
          st_next.nco = acc_sum[`UBR_NCO_W-1:0];
        end
      end

      default: begin
        st_next.state = UBR_RX_ACQ;
      end
    endcase

    // Switch at once on any coding fault; first fallback bit follows 179 clocks
    // later, just over one bit period, far inside the deadline
    if (fault) begin
      st_next.state = UBR_RX_FALLBACK;
      st_next.fallback = 1'b1;
      st_next.locked = 1'b0;
      st_next.gap_cnt = `UBR_GAP_BITS;
      st_next.idx = '0;
      st_next.nco = '0;
      st_next.air_stb = 1'b0;
    end
  end

  // Every energisation starts a fresh judgement from acquisition
  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg <= RX_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bits leave in arrival order with no look at their content
  assign air_bit = st_reg.air_bit;
  assign air_stb = st_reg.air_stb;
  assign fallback = st_reg.fallback;
  assign locked = st_reg.locked;

endmodule : ubr_beacon_end

// >>> ubr_link_monitor.sv
/* Checker on the encoder-to-beacon link and the beacon outputs.
   Assumes one clock and one srst shared by both ends. */
`timescale 1ns/100ps

module ubr_link_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic line_lvl,
  input wire logic air_stb,
  input wire logic fallback,
  input wire logic locked
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_edge;
    $changed(line_lvl);
  endsequence
  sequence s_quiet;
    $stable(line_lvl) [*8];
  endsequence
  a_line_quiet: assert property (s_edge |=> s_quiet)
    else $error("line edges too close");
  // No handshake, so the line never idles while the encoder runs
  a_line_alive: assert property (1'b1 |-> ##[1:200] s_edge)
    else $error("line idle too long");
  a_stb_pulse: assert property (air_stb |=> !air_stb)
    else $error("output strobe too long");
  a_stb_edge: assert property (air_stb && locked |-> ($past(line_lvl, 2) != $past(line_lvl, 3))
    || ($past(line_lvl, 1) != $past(line_lvl, 2)) || (line_lvl != $past(line_lvl, 1)))
    else $error("bit without line edge");
  a_fallback_hold: assert property (fallback |=> fallback)
    else $error("fallback dropped");
  a_fallback_unlock: assert property (fallback |-> !locked)
    else $error("locked during fallback");
  a_lock_loss: assert property ($fell(locked) |-> fallback)
    else $error("lock lost without fallback");
  a_idle_silent: assert property (!locked && !fallback |-> !air_stb)
    else $error("output before decision");
  a_first_bit: assert property ($rose(locked) |-> ##[1:300] air_stb)
    else $error("no bit after lock");
  a_fallback_out: assert property ($rose(fallback) |-> ##[1:400] air_stb)
    else $error("no fallback output");
endmodule : ubr_link_monitor

// >>> uplink_biphase_receiver_tb.sv
/* Bench: encoder feeds one beacon directly and one through swapped wires.
   Assumes the design files and interface are compiled first. */
`timescale 1ns/100ps

module uplink_biphase_receiver_tb;
  import ubr_pkg::*;
  localparam int ACQ = 2000;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic tx_bit = 1'b1;
  logic tx_gap_req = 1'b0;
  logic cut = 1'b0;
  logic rnd = 1'b0;
  logic cmp_swap = 1'b0;
  logic [`UBR_TGM_LEN-1:0] tgm = '0;
  logic tx_take, tx_gap_busy, air_bit, air_stb, fallback, locked;
  logic air_bit2, air_stb2, fallback2, locked2;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  bit sent[$];
  bit got[$];
  ubr_link_if link();
  ubr_link_if link2();
  // A cut wire reads as a stuck level
  assign link2.line_lvl = cut ? 1'b1 : ~link.line_lvl;
  ubr_encoder_end ubr_encoder_end_inst (.clock(clock), .srst(srst), .link(link),
    .tx_bit(tx_bit), .tx_gap_req(tx_gap_req), .tx_take(tx_take), .tx_gap_busy(tx_gap_busy));
  ubr_beacon_end #(.ACQ_CYC(ACQ)) ubr_beacon_end_inst (.clock(clock), .srst(srst),
    .link(link), .stored_tgm(tgm), .air_bit(air_bit), .air_stb(air_stb),
    .fallback(fallback), .locked(locked));
  ubr_beacon_end #(.ACQ_CYC(ACQ)) ubr_beacon_end_swap_inst (.clock(clock), .srst(srst),
    .link(link2), .stored_tgm(tgm), .air_bit(air_bit2), .air_stb(air_stb2),
    .fallback(fallback2), .locked(locked2));
  ubr_link_monitor ubr_link_monitor_inst (.clock(clock), .srst(srst),
    .line_lvl(link.line_lvl), .air_stb(air_stb), .fallback(fallback), .locked(locked));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Decoded stream must be an unbroken run of what was sent
  function automatic bit aligned();
    bit ok;
    for (int off = 0; off <= sent.size() - got.size(); off++) begin
      ok = 1'b1;
      foreach (got[i]) if (got[i] != sent[off + i]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction : aligned

  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      give_verdict();
    end
    if (tx_take === 1'b1) begin
      sent.push_back(tx_bit);
      tx_bit <= rnd ? 1'($urandom) : 1'b1;
      if (rnd && sent.size() == 60) begin
        tx_gap_req <= 1'b1;
        repeat (100) sent.push_back(1'b1);
      end
    end
    if (tx_gap_busy === 1'b1) tx_gap_req <= 1'b0;
    if (air_stb === 1'b1) begin
      got.push_back(air_bit);
      if (cmp_swap) begin
        check("swap stb", air_stb2, 1'b1);
        check("swap bit", air_bit2, air_bit);
      end
    end
  end

  initial begin
    int k;
    int n0;
    void'($urandom(8));
    for (k = 0; k < `UBR_TGM_LEN; k++) tgm[k] = 1'($urandom);
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    // Ones only: never locks, so both beacons fall back
    for (k = 0; k < ACQ + 1000 && fallback !== 1'b1; k++) @(posedge clock);
    check("ones fallback", fallback, 1'b1);
    check("ones fallback swap", fallback2, 1'b1);
    n0 = got.size();
    for (k = 0; k < 20000 && got.size() < n0 + 108; k++) @(posedge clock);
    for (k = 0; k < 108; k++) check("fallback bit", got[n0 + k], k < 100 ? 1'b0 : tgm[k - 100]);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    sent.delete();
    got.delete();
    check("fallback cleared", fallback, 1'b0);
    srst <= 1'b0;
    rnd <= 1'b1;
    cmp_swap <= 1'b1;
    for (k = 0; k < 30000 && got.size() < 150; k++) @(posedge clock);
    check("stream order", aligned(), 1'b1);
    check("gap done", tx_gap_busy, 1'b0);
    cmp_swap <= 1'b0;
    cut <= 1'b1;
    for (k = 0; k < 341 * 178 && fallback2 !== 1'b1; k++) @(posedge clock);
    check("loss fallback", fallback2, 1'b1);
    cut <= 1'b0;
    for (k = 0; k < 2000 && locked2 !== 1'b1; k++) @(posedge clock);
    check("fallback kept", fallback2, 1'b1);
    check("direct still locked", locked, 1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (k = 0; k < ACQ && locked2 !== 1'b1; k++) @(posedge clock);
    check("relock", locked2, 1'b1);
    give_verdict();
  end
endmodule : uplink_biphase_receiver_tb
